/* File: logic/flex_io_pkg.sv */
// Shared constants, register map and carrier types for the flexible pin block.
// Assumes a 32-bit Avalon-MM register bus with byte addressing and four pins.

package flex_io_pkg;

	// ----------------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------------
	localparam int PIN_COUNT = 4;
	localparam int MASK_WIDTH = 16;
	localparam int DATA_WIDTH = 32;
	localparam int ADDR_WIDTH = 5;
	localparam int LANE_WIDTH = 8;

	// ----------------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------------
	localparam logic [4:0] OFS_DIRECTION = 5'h00;
	localparam logic [4:0] OFS_PULL_SELECT = 5'h04;
	localparam logic [4:0] OFS_ALT_FUNCTION = 5'h08;
	localparam logic [4:0] OFS_CONTROL = 5'h0c;
	localparam logic [4:0] OFS_OUT_VALUE = 5'h10;
	localparam logic [4:0] OFS_STATUS = 5'h14;

	// ----------------------------------------------------------------------
	// Reset values and field positions
	// ----------------------------------------------------------------------
	localparam logic [3:0] MASK_RESET = 4'h0;
	localparam logic CONTROL_RESET = 1'b0;
	localparam int CTRL_CD_MODE_BIT = 0;
	localparam int STEP_CLOCK_PIN = 1;
	localparam int STEP_DIRECTION_PIN = 2;
	localparam logic [3:0] CD_PIN_MASK = 4'h6;
	localparam int STAT_LEVEL_LSB = 0;
	localparam int STAT_OUTPUT_LSB = 4;
	localparam int STAT_ALT_LSB = 8;
	localparam int STAT_CD_MODE_BIT = 12;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// ----------------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic [PIN_COUNT-1:0] alt;
		logic [PIN_COUNT-1:0] dir;
		logic [PIN_COUNT-1:0] pull;
	} pin_cfg_t;

	typedef struct packed {
		logic [PIN_COUNT-1:0] out;
		logic [PIN_COUNT-1:0] oe_n;
		logic [PIN_COUNT-1:0] pull_up;
		logic [PIN_COUNT-1:0] pull_down;
	} pin_drive_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ANSWER = 2'b10
	} bus_state_t;

endpackage

/* File: logic/flex_io_sync.sv */
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes the inputs are raw pad levels with no relation to clk.

module flex_io_sync #(
	parameter int WIDTH = 4
) (
	input wire logic clk, // System clock.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic [WIDTH-1:0] async_in, // Raw pad levels.
	output logic [WIDTH-1:0] sync_out // Levels after two flops.
);

	// ----------------------------------------------------------------------
	// Per-bit two-stage chain
	// ----------------------------------------------------------------------
	initial begin
		if (WIDTH < 1) begin
			$error("flex_io_sync needs at least one bit");
		end
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta;
			logic settled;
			always_ff @(posedge clk) begin
				if (rst) begin
					meta <= 1'b0;
					settled <= 1'b0;
				end else begin
					meta <= async_in[i];
					settled <= meta;
				end
			end
			assign sync_out[i] = settled;
		end
	endgenerate

endmodule

/* File: logic/flex_io_pin_config.sv */
// Configuration and drive logic for four flexible digital pins with an Avalon-MM slave.
// Assumes pads resolve level from out/oe_n and apply the pull requests; one clock.

module flex_io_pin_config
	import flex_io_pkg::*;
#(
	parameter int PINS = flex_io_pkg::PIN_COUNT
) (
	input wire logic clk, // System clock, 100 MHz.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic [flex_io_pkg::ADDR_WIDTH-1:0] address, // Avalon byte address.
	input wire logic read, // Avalon read request.
	input wire logic write, // Avalon write request.
	input wire logic [flex_io_pkg::DATA_WIDTH-1:0] writedata, // Avalon write data.
	input wire logic [3:0] byteenable, // Avalon byte enables.
	output logic [flex_io_pkg::DATA_WIDTH-1:0] readdata, // Avalon read data.
	output logic waitrequest, // Avalon wait request.
	input wire logic [flex_io_pkg::PIN_COUNT-1:0] pin_in, // Pad input levels.
	output flex_io_pkg::pin_drive_t pin_drive, // Pad drive and pull requests.
	input wire logic [flex_io_pkg::PIN_COUNT-1:0] alt_out_value, // Alternate-use output data.
	output logic [flex_io_pkg::PIN_COUNT-1:0] alt_in_value, // Levels of alternate-use input pins.
	output logic step_clock, // Step clock from pin two.
	output logic step_direction, // Direction from pin three.
	output logic cd_mode_active // Clock-direction mode is on.
);

	import flex_io_pkg::*;

	// ----------------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------------
	initial begin
		if (PINS != PIN_COUNT) begin
			$error("flex_io_pin_config serves exactly the package pin count");
		end
		if (PIN_COUNT > LANE_WIDTH || STEP_DIRECTION_PIN >= PIN_COUNT) begin
			$error("flex_io_pin_config pin layout does not fit the masks");
		end
	end

	// ----------------------------------------------------------------------
	// Pin input synchroniser
	// ----------------------------------------------------------------------
	logic [PIN_COUNT-1:0] pin_level;

	flex_io_sync #(
		.WIDTH(PIN_COUNT)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.async_in(pin_in),
		.sync_out(pin_level)
	);

	// ----------------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------------
	// Every request is answered one cycle after it is first seen: the state
	// moves to BUS_ANSWER, waitrequest drops for that single cycle and the
	// read data are already registered. The write commits on the edge that ends that cycle.
	bus_state_t state;
	bus_state_t next_state;
	wire request = read | write;
	wire answering = (state == BUS_ANSWER);
	wire commit_write = answering & write;

	always_comb begin
		case (state)
			BUS_IDLE: next_state = request ? BUS_ANSWER : BUS_IDLE;
			BUS_ANSWER: next_state = BUS_IDLE;
			default: next_state = BUS_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= BUS_IDLE;
			waitrequest <= 1'b1;
		end else begin
			state <= next_state;
			waitrequest <= (next_state != BUS_ANSWER);
		end
	end

	// ----------------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------------
	wire hit_direction = (address == OFS_DIRECTION);
	wire hit_pull = (address == OFS_PULL_SELECT);
	wire hit_alt = (address == OFS_ALT_FUNCTION);
	wire hit_control = (address == OFS_CONTROL);
	wire hit_out_value = (address == OFS_OUT_VALUE);
	wire hit_status = (address == OFS_STATUS);

	// Only the pins live in byte lane 0; bits 4 to 31 are not stored at all.
	wire lane0 = byteenable[0];
	wire [PIN_COUNT-1:0] wr_pins = writedata[PIN_COUNT-1:0];
	wire wr_cd_mode = writedata[CTRL_CD_MODE_BIT];

	// ----------------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------------
	logic [PIN_COUNT-1:0] pin_direction_mask;
	logic [PIN_COUNT-1:0] pin_pull_select_mask;
	logic [PIN_COUNT-1:0] pin_alt_function_mask;
	logic [PIN_COUNT-1:0] pin_out_value;
	logic cd_mode_enable;

	always_ff @(posedge clk) begin
		if (rst) begin
			pin_direction_mask <= MASK_RESET;
			pin_pull_select_mask <= MASK_RESET;
			pin_alt_function_mask <= MASK_RESET;
			pin_out_value <= MASK_RESET;
			cd_mode_enable <= CONTROL_RESET;
		end else if (commit_write && lane0) begin
			if (hit_direction) begin
				pin_direction_mask <= wr_pins;
			end
			if (hit_pull) begin
				pin_pull_select_mask <= wr_pins;
			end
			if (hit_alt) begin
				pin_alt_function_mask <= wr_pins;
			end
			if (hit_out_value) begin
				pin_out_value <= wr_pins;
			end
			if (hit_control) begin
				cd_mode_enable <= wr_cd_mode;
			end
		end
	end

	// ----------------------------------------------------------------------
	// Effective configuration
	// ----------------------------------------------------------------------
	// Clock-direction mode takes over pins two and three whatever the masks
	// hold: both become alternate-use inputs. The masks keep their contents
	// so that leaving the mode restores the software setup.
	pin_cfg_t cfg;
	wire [PIN_COUNT-1:0] cd_force = cd_mode_enable ? CD_PIN_MASK : MASK_RESET;
	wire [PIN_COUNT-1:0] alt_active = pin_alt_function_mask | cd_force;
	// Pins two and three have input-only alternate uses, so their direction
	// bit is ignored while the alternate use is on.
	wire [PIN_COUNT-1:0] alt_input_only = alt_active & CD_PIN_MASK;

	assign cfg.alt = alt_active;
	assign cfg.dir = pin_direction_mask & ~alt_input_only;
	assign cfg.pull = pin_pull_select_mask;

	// ----------------------------------------------------------------------
	// Per-pin drive selection
	// ----------------------------------------------------------------------
	pin_drive_t next_drive;

	genvar i;
	generate
		for (i = 0; i < PIN_COUNT; i++) begin : g_pin
			wire is_output = cfg.dir[i];
			wire out_source = cfg.alt[i] ? alt_out_value[i] : pin_out_value[i];
			assign next_drive.out[i] = is_output & out_source;
			assign next_drive.oe_n[i] = ~is_output;
			assign next_drive.pull_up[i] = ~is_output & cfg.pull[i];
			assign next_drive.pull_down[i] = ~is_output & ~cfg.pull[i];
		end
	endgenerate

	// ----------------------------------------------------------------------
	// Alternate-use inputs
	// ----------------------------------------------------------------------
	wire [PIN_COUNT-1:0] next_alt_in = pin_level & cfg.alt & ~cfg.dir;
	wire next_step_clock = cfg.alt[STEP_CLOCK_PIN] & pin_level[STEP_CLOCK_PIN];
	wire next_step_dir = cfg.alt[STEP_DIRECTION_PIN] & pin_level[STEP_DIRECTION_PIN];

	always_ff @(posedge clk) begin
		if (rst) begin
			pin_drive <= '{out: MASK_RESET, oe_n: ~MASK_RESET, pull_up: MASK_RESET,
				pull_down: ~MASK_RESET};
			alt_in_value <= MASK_RESET;
			step_clock <= 1'b0;
			step_direction <= 1'b0;
			cd_mode_active <= 1'b0;
		end else begin
			pin_drive <= next_drive;
			alt_in_value <= next_alt_in;
			step_clock <= next_step_clock;
			step_direction <= next_step_dir;
			cd_mode_active <= cd_mode_enable;
		end
	end

	// ----------------------------------------------------------------------
	// Read-back
	// ----------------------------------------------------------------------
	// Mask registers return their pin bits with everything above as zero.
	// Unmapped addresses read as zero and ignore writes.
	logic [DATA_WIDTH-1:0] status_word;
	logic [DATA_WIDTH-1:0] read_word;

	always_comb begin
		status_word = READ_ZERO;
		status_word[STAT_LEVEL_LSB +: PIN_COUNT] = pin_level;
		status_word[STAT_OUTPUT_LSB +: PIN_COUNT] = cfg.dir;
		status_word[STAT_ALT_LSB +: PIN_COUNT] = cfg.alt;
		status_word[STAT_CD_MODE_BIT] = cd_mode_enable;
	end

	always_comb begin
		read_word = READ_ZERO;
		if (hit_direction) begin
			read_word[PIN_COUNT-1:0] = pin_direction_mask;
		end else if (hit_pull) begin
			read_word[PIN_COUNT-1:0] = pin_pull_select_mask;
		end else if (hit_alt) begin
			read_word[PIN_COUNT-1:0] = pin_alt_function_mask;
		end else if (hit_out_value) begin
			read_word[PIN_COUNT-1:0] = pin_out_value;
		end else if (hit_control) begin
			read_word[CTRL_CD_MODE_BIT] = cd_mode_enable;
		end else if (hit_status) begin
			read_word = status_word;
		end
	end

	wire capture_read = (state == BUS_IDLE) & read;

	always_ff @(posedge clk) begin
		if (rst) begin
			readdata <= READ_ZERO;
		end else if (capture_read) begin
			readdata <= read_word;
		end
	end

endmodule

/* File: dv/flex_io_pin_config_properties.sv */
// Checker for the flexible pin block, watching its ports only.
// Assumes the bind at the foot of this file.

module flex_io_pin_config_properties
	import flex_io_pkg::*;
(
	input wire logic clk, // Clock.
	input wire logic rst, // Reset.
	input wire logic read, // Bus read.
	input wire logic write, // Bus write.
	input wire logic waitrequest, // Bus wait.
	input wire logic [flex_io_pkg::PIN_COUNT-1:0] pin_in, // Pads.
	input wire flex_io_pkg::pin_drive_t pin_drive, // Drive.
	input wire logic [flex_io_pkg::PIN_COUNT-1:0] alt_in_value, // Alt levels.
	input wire logic step_clock, // Step clock.
	input wire logic step_direction, // Direction.
	input wire logic cd_mode_active // Mode flag.
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_cd_held;
		cd_mode_active [*4];
	endsequence

	property p_answer_once;
		$fell(waitrequest) |=> waitrequest;
	endproperty
	a_answer_once: assert property (p_answer_once)
		else $error("wait low too long");
	property p_answer_bound;
		(read || write) && waitrequest |-> ##[1:2] !waitrequest;
	endproperty
	a_answer_bound: assert property (p_answer_bound)
		else $error("no answer");
	property p_answer_cause;
		$fell(waitrequest) |-> $past(read || write);
	endproperty
	a_answer_cause: assert property (p_answer_cause)
		else $error("answer without request");
	property p_no_pull_out;
		(~pin_drive.oe_n & (pin_drive.pull_up | pin_drive.pull_down)) == 4'h0;
	endproperty
	a_no_pull_out: assert property (p_no_pull_out)
		else $error("pull on output");
	property p_one_pull;
		(pin_drive.oe_n & ~(pin_drive.pull_up ^ pin_drive.pull_down)) == 4'h0;
	endproperty
	a_one_pull: assert property (p_one_pull)
		else $error("input pull not single");
	property p_reset_state;
		$fell(rst) |-> waitrequest && pin_drive.oe_n == 4'hf && pin_drive.pull_down == 4'hf;
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("bad state after reset");
	property p_cd_inputs;
		cd_mode_active && $past(cd_mode_active) |-> pin_drive.oe_n[2:1] == 2'h3;
	endproperty
	a_cd_inputs: assert property (p_cd_inputs)
		else $error("mode pins driven");
	property p_step_clk;
		s_cd_held |-> step_clock == $past(pin_in[1], 3);
	endproperty
	a_step_clk: assert property (p_step_clk)
		else $error("step clock wrong");
	property p_step_dir;
		s_cd_held |-> step_direction == $past(pin_in[2], 3);
	endproperty
	a_step_dir: assert property (p_step_dir)
		else $error("direction wrong");
	property p_alt_pair;
		s_cd_held |-> alt_in_value[2:1] == {step_direction, step_clock};
	endproperty
	a_alt_pair: assert property (p_alt_pair)
		else $error("alt levels disagree");
endmodule

bind flex_io_pin_config flex_io_pin_config_properties i_props (
	.clk(clk), .rst(rst), .read(read), .write(write), .waitrequest(waitrequest),
	.pin_in(pin_in), .pin_drive(pin_drive), .alt_in_value(alt_in_value),
	.step_clock(step_clock), .step_direction(step_direction),
	.cd_mode_active(cd_mode_active)
);

/* File: dv/flex_io_pads.sv */
// Pad model: resolves each pin from the block's drive and an outside source.
// Assumes undriven pins with no outside source settle to their pull.

module flex_io_pads
	import flex_io_pkg::*;
(
	input wire flex_io_pkg::pin_drive_t pin_drive, // Drive from block.
	input wire logic [3:0] ext_en, // Outside source on.
	input wire logic [3:0] ext_val, // Outside level.
	output logic [3:0] pin_in // Resolved levels.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] float_level;
	assign float_level = (ext_en & ext_val) | (~ext_en & pin_drive.pull_up);
	assign pin_in = (~pin_drive.oe_n & pin_drive.out) | (pin_drive.oe_n & float_level);
endmodule

/* File: dv/flex_io_pin_config_tb_top.sv */
// Self-checking bench for the flexible pin block over Avalon-MM.
// Assumes the pad model closes the pin loop and the checker is bound in.

module flex_io_pin_config_tb_top
	import flex_io_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [4:0] address = 5'h00;
	logic read = 1'h0;
	logic write = 1'h0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'hf;
	logic [31:0] readdata;
	logic waitrequest;
	logic [3:0] pin_in, alt_in_value, d, p, a, v, ea, ed, lvl;
	logic [3:0] alt_out_value = 4'h0;
	logic [3:0] ext_en = 4'h0;
	logic [3:0] ext_val = 4'h0;
	pin_drive_t pin_drive;
	logic step_clock, step_direction, cd_mode_active, cd;
	logic [31:0] exp_q[$];
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;

	flex_io_pin_config i_flex_io_pin_config (.clk(clk), .rst(rst), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .pin_in(pin_in),
		.pin_drive(pin_drive), .alt_out_value(alt_out_value), .alt_in_value(alt_in_value),
		.step_clock(step_clock), .step_direction(step_direction),
		.cd_mode_active(cd_mode_active));
	flex_io_pads i_flex_io_pads (.pin_drive(pin_drive), .ext_en(ext_en),
		.ext_val(ext_val), .pin_in(pin_in));

	initial begin
		forever #5 clk = ~clk;
	end

	task automatic complete_run();
		$display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] expected);
		comparisons++;
		if (seen !== expected) begin
			num_errors++;
			$display("ERROR readdata expected %h seen %h", expected, seen);
		end
	endtask

	// Bus request held until waitrequest is seen low; reads note their expectation.
	task automatic bus(input logic [4:0] ad, input logic wr, input logic [31:0] wd,
		input logic [31:0] e);
		address <= ad;
		write <= wr;
		read <= !wr;
		writedata <= wd;
		if (!wr)
			exp_q.push_back(e);
		@(posedge clk);
		while (waitrequest)
			@(posedge clk);
		write <= 1'h0;
		read <= 1'h0;
		@(posedge clk);
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles > 20000) begin
			num_errors++;
			complete_run();
		end else if (read && !waitrequest) begin
			check(readdata, exp_q.pop_front());
		end
	end

	initial begin
		void'($urandom(91599));
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		for (int i = 0; i < 7; i++)
			bus(5'(4 * i), 1'h0, 32'h0, 32'h0);
		bus(OFS_DIRECTION, 1'h1, 32'hffff, 32'h0);
		bus(OFS_DIRECTION, 1'h0, 32'h0, 32'hf);
		byteenable <= 4'h0;
		bus(OFS_PULL_SELECT, 1'h1, 32'hf, 32'h0);
		byteenable <= 4'hf;
		bus(OFS_PULL_SELECT, 1'h0, 32'h0, 32'h0);
		bus(OFS_STATUS, 1'h1, 32'hffff, 32'h0);
		for (int n = 0; n < 24; n++) begin
			{d, p, a, v} = 16'($urandom);
			cd = 1'($urandom);
			alt_out_value <= 4'($urandom);
			ext_en <= 4'($urandom);
			ext_val <= 4'($urandom);
			bus(OFS_DIRECTION, 1'h1, {28'($urandom), d}, 32'h0);
			bus(OFS_PULL_SELECT, 1'h1, {28'($urandom), p}, 32'h0);
			bus(OFS_ALT_FUNCTION, 1'h1, {28'($urandom), a}, 32'h0);
			bus(OFS_OUT_VALUE, 1'h1, {28'h0, v}, 32'h0);
			bus(OFS_CONTROL, 1'h1, {31'h0, cd}, 32'h0);
			repeat (6) @(posedge clk);
			ea = cd ? (a | CD_PIN_MASK) : a;
			ed = d & ~(ea & CD_PIN_MASK);
			lvl = (~ed & ext_en & ext_val) | (~ed & ~ext_en & p)
				| (ed & ((ea & alt_out_value) | (~ea & v)));
			bus(OFS_STATUS, 1'h0, 32'h0, {19'h0, cd, ea, ed, lvl});
			bus(OFS_ALT_FUNCTION, 1'h0, 32'h0, {28'h0, a});
			bus(OFS_PULL_SELECT, 1'h0, 32'h0, {28'h0, p});
			bus(OFS_CONTROL, 1'h0, 32'h0, {31'h0, cd});
		end
		complete_run();
	end
endmodule
